// file: stil_jtag_ctrl.sv
// boundary-scan controller model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module stil_jtag_ctrl (
    // system clock, only to align stimulus
    input  wire logic i_clk,
    // test port pins
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    // tck rests low between frames, tdi idles at its pull-up level
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // one 160 ns tck period, tdo taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge i_clk);
        #1;
        o_tms = tms;
        o_tdi = tdi;
        #40;
        tdo = i_tdo;
        o_tck = 1'b1;
        #80;
        o_tck = 1'b0;
        #38;
    endtask
    task automatic go(input logic [7:0] seq, input int n);
        logic t;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b1, t);
        end
    endtask
    // lsb first, last bit leaves for exit1
    task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic t;
        dout = 32'h0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
    endtask
    task automatic tlr();
        go(8'h1f, 6);
    endtask
    task automatic to_shir();
        go(8'h03, 4);
    endtask
    task automatic to_shdr();
        go(8'h01, 3);
    endtask
    task automatic upd();
        go(8'h01, 2);
    endtask
endmodule
`default_nettype wire

// file: stil_pkg.sv
// shared constants and types of the test port instruction logic
package stil_pkg;

    localparam int          IR_W        = 3;
    localparam int          ID_W        = 32;
    localparam int          PIN_N       = 8;
    localparam int          FILL_N      = 2;
    localparam int          BSR_W       = PIN_N + FILL_N;
    localparam int          FIFO_DEPTH  = 8;
    localparam int          FIFO_W      = 2;

    // instruction codes, msb written on the left
    localparam logic [2:0]  IR_EXTEST   = 3'h0;
    localparam logic [2:0]  IR_IDCODE   = 3'h1;
    localparam logic [2:0]  IR_SAMPLEZ  = 3'h2;
    localparam logic [2:0]  IR_SAMPLE   = 3'h4;
    localparam logic [2:0]  IR_BYPASS   = 3'h7;

    // capture pattern of the instruction register
    localparam logic [2:0]  IR_CAPTURE  = 3'h1;
    // default of the cells with no pin behind them
    localparam logic [FILL_N-1:0] FILL_DEFAULT = 2'h3;

    // reset values
    localparam logic [2:0]  IR_RESET    = IR_IDCODE;
    localparam logic        TDO_RESET   = 1'h0;

    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_RTI   = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PADR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PAIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } stil_tap_t;

endpackage

// file: stil_top.sv
// test port instruction logic: tap, instruction register, data registers, tdo fifo
//
// Contract
// - Capture-IR loads 01 into low bits
// - Shift-IR shifts instruction between TDI and TDO
// - new instruction acts only at Update-IR
// - code 111 selects one-bit bypass register
// - code 100 Capture-DR samples pin ring
// - unpinned boundary cells capture fixed defaults
// - code 100 shifts boundary register in Shift-DR
// - code 000 is external test, boundary path
// - external test never blocks RAM inputs
// - external test drives outputs at Update-IR fall
// - external test Capture-DR loads pins and defaults
// - code 001 captures and shifts ID register
// - ID instruction loaded at reset and TLR
// - code 010 floats outputs, boundary path
// - codes are 3-bit, msb on left
// - instruction register 3 bits, loaded in path
// - five TMS highs reach Test-Logic-Reset
// - ID bit 0 leaves first on TDO
`timescale 1ns/1ps
`default_nettype none

module stil_fifo #(
    parameter int W = 2,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // fill side
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    // drain side
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
    } stil_fifo_st_t;

    stil_fifo_st_t st_ff;
    stil_fifo_st_t nxt_st;
    logic          push;
    logic          pop;

    assign o_in_ready  = (st_ff.cnt != CW'(D));
    assign o_out_valid = (st_ff.cnt != '0);
    assign o_out_data  = st_ff.mem[st_ff.rp];

    always_comb begin
        nxt_st = st_ff;
        push   = i_in_valid && o_in_ready;
        pop    = o_out_valid && i_out_ready;
        if (push) begin
            nxt_st.mem[st_ff.wp] = i_in_data;
            nxt_st.wp = (st_ff.wp == AW'(D - 1)) ? '0 : st_ff.wp + AW'(1);
        end
        if (pop) begin
            nxt_st.rp = (st_ff.rp == AW'(D - 1)) ? '0 : st_ff.rp + AW'(1);
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - CW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

module stil_top #(
    // arbitrary values, not any real part's identity
    parameter logic [19:0] ID_UPPER = 20'h00000,
    parameter logic [10:0] ID_MAKER = 11'h2a5
) (
    // clock and reset
    input  wire logic                         I_CLK,
    input  wire logic                         I_ARST_N,
    // test port pins
    input  wire logic                         I_TCK,
    input  wire logic                         I_TMS,
    input  wire logic                         I_TDI,
    output logic                              O_TDO,
    output logic                              O_TDO_OE,
    // ram pin ring
    input  wire logic [stil_pkg::PIN_N-1:0]   I_PIN,
    output logic [stil_pkg::PIN_N-1:0]        O_PIN_DRV,
    output logic                              O_PIN_DRV_EN,
    output logic                              O_RAM_HIZ,
    // active instruction
    output logic [stil_pkg::IR_W-1:0]         O_IR
);
    typedef struct packed {
        logic                          tck_s1;
        logic                          tck_s2;
        logic                          tck_prev;
        logic                          tms_s1;
        logic                          tms_s2;
        logic                          tdi_s1;
        logic                          tdi_s2;
        logic [stil_pkg::PIN_N-1:0]    pin_s1;
        logic [stil_pkg::PIN_N-1:0]    pin_s2;
        logic                          pend;
        logic                          tms;
        logic                          tdi;
        stil_pkg::stil_tap_t           tap;
        logic [stil_pkg::IR_W-1:0]     ir_sh;
        logic [stil_pkg::IR_W-1:0]     ir_act;
        logic                          byp;
        logic [stil_pkg::ID_W-1:0]     idr;
        logic [stil_pkg::BSR_W-1:0]    bsr;
        logic [stil_pkg::PIN_N-1:0]    bsr_upd;
        logic                          drv_en;
        logic                          hiz;
        logic                          tdo;
        logic                          tdo_oe;
    } stil_top_st_t;

    localparam logic [stil_pkg::ID_W-1:0] ID_VALUE = {ID_UPPER, ID_MAKER, 1'b1};

    stil_top_st_t                 st_ff;
    stil_top_st_t                 nxt_st;
    logic                         rise;
    logic                         fall;
    logic                         push;
    logic [stil_pkg::FIFO_W-1:0]  push_data;
    logic                         fifo_in_rdy;
    logic                         fifo_out_vld;
    logic [stil_pkg::FIFO_W-1:0]  fifo_out_data;

    // boundary register selection; private codes fall to bypass
    function automatic logic sel_bsr(input logic [2:0] ir);
        sel_bsr = (ir == stil_pkg::IR_EXTEST) || (ir == stil_pkg::IR_SAMPLEZ)
               || (ir == stil_pkg::IR_SAMPLE);
    endfunction

    function automatic logic sel_id(input logic [2:0] ir);
        sel_id = (ir == stil_pkg::IR_IDCODE);
    endfunction

    function automatic stil_pkg::stil_tap_t tap_next(input stil_pkg::stil_tap_t s,
                                                     input logic tms);
        case (s)
            stil_pkg::ST_TLR:   tap_next = tms ? stil_pkg::ST_TLR   : stil_pkg::ST_RTI;
            stil_pkg::ST_RTI:   tap_next = tms ? stil_pkg::ST_SELDR : stil_pkg::ST_RTI;
            stil_pkg::ST_SELDR: tap_next = tms ? stil_pkg::ST_SELIR : stil_pkg::ST_CAPDR;
            stil_pkg::ST_CAPDR: tap_next = tms ? stil_pkg::ST_EX1DR : stil_pkg::ST_SHDR;
            stil_pkg::ST_SHDR:  tap_next = tms ? stil_pkg::ST_EX1DR : stil_pkg::ST_SHDR;
            stil_pkg::ST_EX1DR: tap_next = tms ? stil_pkg::ST_UPDR  : stil_pkg::ST_PADR;
            stil_pkg::ST_PADR:  tap_next = tms ? stil_pkg::ST_EX2DR : stil_pkg::ST_PADR;
            stil_pkg::ST_EX2DR: tap_next = tms ? stil_pkg::ST_UPDR  : stil_pkg::ST_SHDR;
            stil_pkg::ST_UPDR:  tap_next = tms ? stil_pkg::ST_SELDR : stil_pkg::ST_RTI;
            stil_pkg::ST_SELIR: tap_next = tms ? stil_pkg::ST_TLR   : stil_pkg::ST_CAPIR;
            stil_pkg::ST_CAPIR: tap_next = tms ? stil_pkg::ST_EX1IR : stil_pkg::ST_SHIR;
            stil_pkg::ST_SHIR:  tap_next = tms ? stil_pkg::ST_EX1IR : stil_pkg::ST_SHIR;
            stil_pkg::ST_EX1IR: tap_next = tms ? stil_pkg::ST_UPIR  : stil_pkg::ST_PAIR;
            stil_pkg::ST_PAIR:  tap_next = tms ? stil_pkg::ST_EX2IR : stil_pkg::ST_PAIR;
            stil_pkg::ST_EX2IR: tap_next = tms ? stil_pkg::ST_UPIR  : stil_pkg::ST_SHIR;
            stil_pkg::ST_UPIR:  tap_next = tms ? stil_pkg::ST_SELDR : stil_pkg::ST_RTI;
            default:            tap_next = stil_pkg::ST_TLR;
        endcase
    endfunction

    // tdo bits wait here until the falling tck edge; a full fifo stalls the core
    stil_fifo #(
        .W (stil_pkg::FIFO_W),
        .D (stil_pkg::FIFO_DEPTH)
    ) u_tdo_fifo (
        .i_clk       (I_CLK),
        .i_arst_n    (I_ARST_N),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_rdy),
        .i_in_data   (push_data),
        .o_out_valid (fifo_out_vld),
        .i_out_ready (fall),
        .o_out_data  (fifo_out_data)
    );

    assign fall = !st_ff.tck_s2 && st_ff.tck_prev;
    assign rise = st_ff.tck_s2 && !st_ff.tck_prev;

    always_comb begin
        nxt_st           = st_ff;
        push             = 1'b0;
        push_data        = '0;
        nxt_st.tck_s1    = I_TCK;
        nxt_st.tck_s2    = st_ff.tck_s1;
        nxt_st.tck_prev  = st_ff.tck_s2;
        nxt_st.tms_s1    = I_TMS;
        nxt_st.tms_s2    = st_ff.tms_s1;
        nxt_st.tdi_s1    = I_TDI;
        nxt_st.tdi_s2    = st_ff.tdi_s1;
        // pins are only sampled, never gated toward the ram core
        nxt_st.pin_s1    = I_PIN;
        nxt_st.pin_s2    = st_ff.pin_s1;

        // latch tms and tdi at the rising edge; processing may wait on the fifo
        if (rise) begin
            nxt_st.pend = 1'b1;
            nxt_st.tms  = st_ff.tms_s2;
            nxt_st.tdi  = st_ff.tdi_s2;
        end

        if (st_ff.pend && fifo_in_rdy) begin
            nxt_st.pend = 1'b0;
            case (st_ff.tap)
                stil_pkg::ST_TLR: begin
                    nxt_st.ir_act = stil_pkg::IR_RESET;
                    nxt_st.drv_en = 1'b0;
                    nxt_st.hiz    = 1'b0;
                end
                stil_pkg::ST_CAPIR: begin
                    nxt_st.ir_sh = stil_pkg::IR_CAPTURE;
                end
                stil_pkg::ST_SHIR: begin
                    nxt_st.ir_sh = {st_ff.tdi, st_ff.ir_sh[2:1]};
                end
                stil_pkg::ST_CAPDR: begin
                    if (sel_bsr(st_ff.ir_act)) begin
                        // inputs must be settled here or the sample is not repeatable
                        nxt_st.bsr = {stil_pkg::FILL_DEFAULT, st_ff.pin_s2};
                    end else if (sel_id(st_ff.ir_act)) begin
                        nxt_st.idr = ID_VALUE;
                    end else begin
                        nxt_st.byp = 1'b0;
                    end
                end
                stil_pkg::ST_SHDR: begin
                    if (sel_bsr(st_ff.ir_act)) begin
                        nxt_st.bsr = {st_ff.tdi, st_ff.bsr[stil_pkg::BSR_W-1:1]};
                    end else if (sel_id(st_ff.ir_act)) begin
                        nxt_st.idr = {st_ff.tdi, st_ff.idr[stil_pkg::ID_W-1:1]};
                    end else begin
                        nxt_st.byp = st_ff.tdi;
                    end
                end
                default: begin
                end
            endcase
            nxt_st.tap = tap_next(st_ff.tap, st_ff.tms);

            // bit that tdo shows from the next falling edge
            push = 1'b1;
            if (nxt_st.tap == stil_pkg::ST_SHIR) begin
                push_data = {1'b1, nxt_st.ir_sh[0]};
            end else if (nxt_st.tap == stil_pkg::ST_SHDR) begin
                if (sel_bsr(nxt_st.ir_act)) begin
                    push_data = {1'b1, nxt_st.bsr[0]};
                end else if (sel_id(nxt_st.ir_act)) begin
                    push_data = {1'b1, nxt_st.idr[0]};
                end else begin
                    push_data = {1'b1, nxt_st.byp};
                end
            end
        end

        if (fall) begin
            if (fifo_out_vld) begin
                nxt_st.tdo    = fifo_out_data[0];
                nxt_st.tdo_oe = fifo_out_data[1];
            end
            // shifted instruction and its pin effects take hold here; Test-Logic-Reset loads the reset code and clears them above
            if (st_ff.tap == stil_pkg::ST_UPIR) begin
                nxt_st.ir_act = st_ff.ir_sh;
                nxt_st.drv_en = (st_ff.ir_sh == stil_pkg::IR_EXTEST);
                nxt_st.hiz    = (st_ff.ir_sh == stil_pkg::IR_SAMPLEZ);
            end
            if (st_ff.tap == stil_pkg::ST_UPDR && sel_bsr(st_ff.ir_act)) begin
                nxt_st.bsr_upd = st_ff.bsr[stil_pkg::PIN_N-1:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_ff        <= '0;
            st_ff.tap    <= stil_pkg::ST_TLR;
            st_ff.ir_act <= stil_pkg::IR_RESET;
            st_ff.ir_sh  <= stil_pkg::IR_RESET;
            st_ff.tdo    <= stil_pkg::TDO_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_TDO        = st_ff.tdo;
    assign O_TDO_OE     = st_ff.tdo_oe;
    assign O_PIN_DRV    = st_ff.bsr_upd;
    assign O_PIN_DRV_EN = st_ff.drv_en;
    assign O_RAM_HIZ    = st_ff.hiz;
    assign O_IR         = st_ff.ir_act;
endmodule

`default_nettype wire

// file: stil_top_asserts.sv
// port-level checker of the test port instruction logic
`timescale 1ns/1ps
`default_nettype none
module stil_top_asserts (
    // clock and reset
    input wire logic                       I_CLK,
    input wire logic                       I_ARST_N,
    // test port pins
    input wire logic                       I_TCK,
    input wire logic                       I_TMS,
    input wire logic                       I_TDI,
    input wire logic                       O_TDO,
    input wire logic                       O_TDO_OE,
    // ram pin ring
    input wire logic [stil_pkg::PIN_N-1:0] I_PIN,
    input wire logic [stil_pkg::PIN_N-1:0] O_PIN_DRV,
    input wire logic                       O_PIN_DRV_EN,
    input wire logic                       O_RAM_HIZ,
    // active instruction
    input wire logic [stil_pkg::IR_W-1:0]  O_IR
);
    logic       tck_q;
    logic [3:0] fall_cnt;
    logic [3:0] rise_cnt;
    // cycles since the raw test clock edge, saturating so long idles stay quiet
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tck_q    <= 1'b0;
            fall_cnt <= 4'hf;
            rise_cnt <= 4'hf;
        end else begin
            tck_q    <= I_TCK;
            fall_cnt <= (tck_q && !I_TCK) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
            rise_cnt <= (!tck_q && I_TCK) ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hf};
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    property p_tdo_fall;
        $changed(O_TDO) |-> fall_cnt <= 4'h7;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved away from a tck fall");
    property p_oe_fall;
        $changed(O_TDO_OE) |-> fall_cnt <= 4'h7;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved away from a tck fall");
    property p_drv_fall;
        $changed(O_PIN_DRV) |-> fall_cnt <= 4'h7;
    endproperty
    a_drv_fall: assert property (p_drv_fall) else $error("pin drive moved away from a tck fall");
    property p_ir_tck;
        $changed(O_IR) |-> (fall_cnt <= 4'h7) || (rise_cnt <= 4'h7);
    endproperty
    a_ir_tck: assert property (p_ir_tck) else $error("instruction changed with tck idle");
    property p_extest_en;
        ($stable(O_IR) && O_IR == stil_pkg::IR_EXTEST) [*3] |-> O_PIN_DRV_EN;
    endproperty
    a_extest_en: assert property (p_extest_en) else $error("pin drive off under code 000");
    property p_other_en;
        ($stable(O_IR) && O_IR != stil_pkg::IR_EXTEST) [*3] |-> !O_PIN_DRV_EN;
    endproperty
    a_other_en: assert property (p_other_en) else $error("pin drive on without code 000");
    property p_hiz;
        $stable(O_IR) [*3] |-> O_RAM_HIZ == (O_IR == stil_pkg::IR_SAMPLEZ);
    endproperty
    a_hiz: assert property (p_hiz) else $error("high-z does not follow code 010");
    property p_reset;
        $rose(I_ARST_N) |-> O_IR == stil_pkg::IR_RESET && !O_TDO_OE && !O_PIN_DRV_EN;
    endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
    c_extest: cover property ($rose(O_PIN_DRV_EN));
    c_hiz: cover property ($rose(O_RAM_HIZ));
    c_bypass: cover property (O_IR == stil_pkg::IR_BYPASS);
    c_shift: cover property ($rose(O_TDO_OE));
endmodule
bind stil_top stil_top_asserts i_asserts (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_TCK(I_TCK), .I_TMS(I_TMS),
    .I_TDI(I_TDI), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .I_PIN(I_PIN),
    .O_PIN_DRV(O_PIN_DRV), .O_PIN_DRV_EN(O_PIN_DRV_EN), .O_RAM_HIZ(O_RAM_HIZ), .O_IR(O_IR)
);
`default_nettype wire

// file: stil_top_tb.sv
// self-checking testbench of the test port instruction logic
`timescale 1ns/1ps
`default_nettype none
module stil_top_tb;
    // arbitrary identity fields, not any real part's
    localparam logic [19:0] UP = 20'h5a5a5;
    localparam logic [10:0] MK = 11'h123;
    logic        clk, arst_n, tck, tms, tdi, tdo, tdo_oe, drv_en, hiz;
    logic [7:0]  pin, pin_drv;
    logic [2:0]  ir;
    logic [31:0] d;
    int          n_mismatch, n_tests;
    always #2.5 clk = ~clk;
    stil_top #(.ID_UPPER(UP), .ID_MAKER(MK)) i_dut (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
        .O_TDO(tdo), .O_TDO_OE(tdo_oe), .I_PIN(pin), .O_PIN_DRV(pin_drv),
        .O_PIN_DRV_EN(drv_en), .O_RAM_HIZ(hiz), .O_IR(ir));
    stil_jtag_ctrl i_ctrl (.i_clk(clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic [2:0] code);
        logic [2:0] prev;
        prev = ir;
        i_ctrl.to_shir();
        check(tdo_oe, 1'b1);
        i_ctrl.shift({29'h0, code}, 3, d);
        check(d[1:0], 2'h1);
        check(d, stil_pkg::IR_CAPTURE);
        check(ir, prev);
        i_ctrl.upd();
        check(ir, code);
        check(tdo_oe, 1'b0);
    endtask
    task automatic dr(input logic [31:0] din, input int n);
        i_ctrl.to_shdr();
        i_ctrl.shift(din, n, d);
        i_ctrl.upd();
    endtask
    task automatic t_idcode();
        check({ir, drv_en, hiz}, {stil_pkg::IR_RESET, 2'h0});
        i_ctrl.go(8'h00, 1);
        dr(32'h0, 32);
        check(d, {UP, MK, 1'b1});
    endtask
    // private codes must behave exactly like the bypass code
    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            load(codes[i]);
            check({drv_en, hiz}, 2'h0);
            dr(32'hb, 4);
            check(d, 32'h6);
        end
    endtask
    task automatic t_sample();
        @(posedge clk);
        #1;
        pin = 8'ha5;
        load(stil_pkg::IR_SAMPLE);
        dr(32'h0c3, 10);
        check(d, {stil_pkg::FILL_DEFAULT, 8'ha5});
        check({drv_en, pin_drv}, 9'h0c3);
    endtask
    task automatic t_extest();
        load(stil_pkg::IR_EXTEST);
        check({drv_en, hiz, pin_drv}, 10'h2c3);
        @(posedge clk);
        #1;
        pin = 8'h3c;
        dr(32'h155, 10);
        check(d, {stil_pkg::FILL_DEFAULT, 8'h3c});
        check(pin_drv, 8'h55);
    endtask
    task automatic t_samplez();
        load(stil_pkg::IR_SAMPLEZ);
        check({drv_en, hiz}, 2'h1);
        dr(32'h0, 10);
        check(d, {stil_pkg::FILL_DEFAULT, 8'h3c});
        // from shift-dr all five tms highs are needed to reach reset
        i_ctrl.to_shdr();
        i_ctrl.tlr();
        check({ir, hiz}, {stil_pkg::IR_RESET, 1'b0});
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        pin = 8'h00;
        n_mismatch = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_samplez();
        end_of_test();
    end
    // the whole run needs about 31 us
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
